// *** rtl/xpc_pkg.sv ***
package xpc_pkg;

	// ========================================
	// protocol and power types
	typedef enum logic [1:0] {
		LINES_SINGLE = 2'h0,
		LINES_DUAL   = 2'h1,
		LINES_QUAD   = 2'h2
	} xpc_lines_t;

	typedef enum logic [2:0] {
		PWR_OFF   = 3'h1,
		PWR_RAMP  = 3'h2,
		PWR_READY = 3'h4
	} xpc_power_t;

	// summary of one chip-select frame, held stable while deselected
	typedef struct packed {
		logic [5:0] clocks;
		logic       sawConfirm;
		logic       confirm;
		logic       allOnes;
	} xpc_frame_t;

	// ========================================
	// field layout and encodings
	localparam int         BOOT_XIP_HI     = 11;
	localparam int         BOOT_XIP_LO     = 9;
	localparam logic [2:0] BOOT_XIP_OFF    = 3'h7;
	localparam logic [5:0] CMD_CYCLES      = 6'h08;
	localparam logic [5:0] ADDR_CYC_SINGLE = 6'h18;
	localparam logic [5:0] ADDR_CYC_DUAL   = 6'h0C;
	localparam logic [5:0] ADDR_CYC_QUAD   = 6'h06;
	localparam logic [5:0] NO_DUMMY        = 6'h3F;
	localparam logic [5:0] CLOCK_SAT       = 6'h3F;
	localparam logic [5:0] XIP_VALID_CYCLE = 6'h03;
	localparam logic [1:0] ERASE_INT_4K    = 2'h1;
	localparam logic [1:0] ERASE_INT_32K   = 2'h2;
	localparam logic [2:0] RESYNC_LAST     = 3'h5;

	// ========================================
	// reset values
	localparam logic       VCFG_XIP_RESET  = 1'h1;
	localparam logic [1:0] LOCK_RESET      = 2'h0;

	// ========================================
	// timing
	localparam int CLOCK_KHZ          = 25000;
	localparam int POWER_READY_US     = 300;
	localparam int POWER_READY_4K_US  = 4500;
	localparam int POWER_READY_32K_US = 36000;
	localparam int POWER_READY_CYC    = POWER_READY_US * CLOCK_KHZ / 1000;
	localparam int POWER_READY_4K_CYC = POWER_READY_4K_US * CLOCK_KHZ / 1000;
	localparam int POWER_READY_32K_CYC = POWER_READY_32K_US * CLOCK_KHZ / 1000;
	localparam int TIMER_W            = 20;

endpackage

// *** rtl/xpc_xip_powerup_control.sv ***
`timescale 1ns/10ps
// What this block does
// - boot config bits 11:9 selecting XIP make the device start already in XIP
// - confirmation bit is io0 sampled in the first dummy cycle of a fast read
// - confirmation 0 keeps XIP, or enters it when the volatile XIP-disable bit is 0; confirmation 1 leaves XIP
// - dual-line XIP ignores io1 in the first dummy cycle
// - quad-line XIP ignores io3, io2 and io1 in the first dummy cycle
// - low reset pin sets XIP from boot config bits 11:9 and restores the boot configuration state
// - in quad-line protocol the reset pin acts only while deselected
// - the resync frames end XIP without resetting or stopping operations
// - below the power-on threshold logic is held reset and takes only status and flag status reads
// - during power-up only status and flag status reads are taken
// - after power-up: standby, write latch, busy and lock bits cleared
// - at power-down below threshold only status and flag status reads are taken
// - controller-ready bit reads 0 while busy, 1 when done
// - readiness polled on status bit 0 or flag bit 7, single line
// - after power-up full access in the boot-configured protocol
// - power-ready time stretches after an interrupted subsector erase
// - during power-ready: pause enabled, reset pin off, default drive
// - in XIP every frame starts directly with address bits
// - leaving XIP sets the volatile XIP-disable bit back to 1
module xpc_xip_powerup_control
	import xpc_pkg::*;
#(
	parameter int         READY_CYC     = POWER_READY_CYC,
	parameter int         READY_4K_CYC  = POWER_READY_4K_CYC,
	parameter int         READY_32K_CYC = POWER_READY_32K_CYC,
	parameter logic [7:0] OP_FAST_READ  = 8'h01,
	parameter logic [7:0] OP_DUAL_READ  = 8'h02,
	parameter logic [7:0] OP_QUAD_READ  = 8'h03,
	parameter logic [7:0] OP_READ_STAT  = 8'h04,
	parameter logic [7:0] OP_READ_FLAG  = 8'h05
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        spiClk,
	input  wire logic        csN,
	input  wire logic        io0In,
	input  wire logic        io3In,
	input  wire logic        supplyOk,
	input  wire logic        resetPinN,
	input  wire logic        resetPinFitted,
	input  wire logic [15:0] bootConfig,
	input  wire xpc_lines_t  protocolLines,
	input  wire logic [1:0]  eraseInterrupted,
	input  wire logic        opRunning,
	input  wire logic        welSet,
	input  wire logic        welClear,
	input  wire logic        lockLoad,
	input  wire logic [1:0]  lockValue,
	input  wire logic        vcfgWrite,
	input  wire logic        vcfgXipDisable,
	output logic             xipActive,
	output logic             vcfgXipBit,
	output logic             powerReady,
	output logic             statusBusyBit,
	output logic             flagReadyBit,
	output logic             welBit,
	output logic             wipBit,
	output logic [1:0]       lockBits,
	output logic             pauseEnable,
	output logic             resetPinEnable,
	output logic             driveDefault,
	output logic             cmdAllowed,
	output logic             addrOnlyFrame
);

	initial begin
		if (READY_CYC < 1 || READY_4K_CYC >= (1 << TIMER_W) || READY_32K_CYC >= (1 << TIMER_W))
			$error("power-ready counts do not fit the timer");
	end

	// ========================================
	// link domain: frame tracking on the host clock
	logic             started;
	logic [5:0]       clocks;
	logic [7:0]       cmd;
	logic             sawConfirm;
	logic             confirm;
	logic             allOnes;
	logic             xipMeta, xipSync, pupMeta, pupSync;
	xpc_lines_t       linesMeta, linesSync;
	logic [5:0]       next_clocks;
	logic [7:0]       next_cmd;
	logic             next_sawConfirm, next_confirm, next_allOnes;
	logic [5:0]       dummyIdx;

	function automatic logic [5:0] addrCycles(input xpc_lines_t l);
		unique case (l)
			LINES_DUAL: addrCycles = ADDR_CYC_DUAL;
			LINES_QUAD: addrCycles = ADDR_CYC_QUAD;
			default:    addrCycles = ADDR_CYC_SINGLE;
		endcase
	endfunction

	always_comb begin
		next_clocks     = clocks;
		next_cmd        = cmd;
		next_sawConfirm = sawConfirm;
		next_confirm    = confirm;
		next_allOnes    = allOnes & io0In & io3In;
		if (xipSync)
			dummyIdx = addrCycles(linesSync);
		else if (cmd == OP_FAST_READ)
			dummyIdx = CMD_CYCLES + ADDR_CYC_SINGLE;
		else if (cmd == OP_DUAL_READ)
			dummyIdx = CMD_CYCLES + ADDR_CYC_DUAL;
		else if (cmd == OP_QUAD_READ)
			dummyIdx = CMD_CYCLES + ADDR_CYC_QUAD;
		else
			dummyIdx = NO_DUMMY;
		if (!started) begin
			next_clocks     = 6'h01;
			next_cmd        = {7'h00, io0In};
			next_sawConfirm = 1'b0;
			next_confirm    = 1'b0;
			next_allOnes    = io0In & io3In;
		end else begin
			if (clocks != CLOCK_SAT)
				next_clocks = clocks + 6'h01;
			if (clocks < CMD_CYCLES)
				next_cmd = {cmd[6:0], io0In};
			// sample io0 in first dummy cycle
			// io1 is never looked at here
			// io1 to io3 ignored as confirmation
			if (clocks == dummyIdx && !sawConfirm && clocks >= XIP_VALID_CYCLE) begin
				next_sawConfirm = 1'b1;
				next_confirm    = io0In;
			end
		end
	end

	always_ff @(posedge spiClk or posedge rst or posedge csN) begin
		if (rst || csN)
			started <= 1'b0;
		else
			started <= 1'b1;
	end

	always_ff @(posedge spiClk or posedge rst) begin
		if (rst) begin
			clocks     <= 6'h00;
			cmd        <= 8'h00;
			sawConfirm <= 1'b0;
			confirm    <= 1'b0;
			allOnes    <= 1'b0;
			xipMeta    <= 1'b0;
			xipSync    <= 1'b0;
			pupMeta    <= 1'b0;
			pupSync    <= 1'b0;
			linesMeta  <= LINES_SINGLE;
			linesSync  <= LINES_SINGLE;
		end else begin
			clocks     <= next_clocks;
			cmd        <= next_cmd;
			sawConfirm <= next_sawConfirm;
			confirm    <= next_confirm;
			allOnes    <= next_allOnes;
			xipMeta    <= xipActive;
			xipSync    <= xipMeta;
			pupMeta    <= powerReady;
			pupSync    <= pupMeta;
			linesMeta  <= protocolLines;
			linesSync  <= linesMeta;
		end
	end

	assign cmdAllowed = started && pupSync ? 1'b1 :
		(started && clocks >= CMD_CYCLES && (cmd == OP_READ_STAT || cmd == OP_READ_FLAG));
	// synced XIP state is stale until the third clock of a frame
	assign addrOnlyFrame = started & xipSync & (clocks >= XIP_VALID_CYCLE);

	// ========================================
	// system domain: synchronisers
	logic csMeta, csSync, csPrev, supMeta, supSync, rpMeta, rpSync;
	logic frameEnd;
	xpc_frame_t frame;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			csMeta  <= 1'b1;
			csSync  <= 1'b1;
			csPrev  <= 1'b1;
			supMeta <= 1'b0;
			supSync <= 1'b0;
			rpMeta  <= 1'b1;
			rpSync  <= 1'b1;
		end else begin
			csMeta  <= csN;
			csSync  <= csMeta;
			csPrev  <= csSync;
			supMeta <= supplyOk;
			supSync <= supMeta;
			rpMeta  <= resetPinN;
			rpSync  <= rpMeta;
		end
	end

	// link summary is static while deselected, read after the cs level is synced
	assign frameEnd = csSync & ~csPrev;
	assign frame    = '{clocks: clocks, sawConfirm: sawConfirm, confirm: confirm,
		allOnes: allOnes};

	// ========================================
	// system domain: power, XIP and status state
	xpc_power_t           pwr, next_pwr;
	logic [TIMER_W-1:0]   timer, next_timer;
	logic [2:0]           resyncIdx, next_resyncIdx;
	logic                 fitted, next_fitted;
	logic                 next_xip, next_vcfg, next_wel, next_busy, next_flag;
	logic [1:0]           next_lock;
	logic                 bootXip, pinReset, resyncHit;

	function automatic logic [5:0] resyncLen(input logic [2:0] i);
		unique case (i)
			3'h0:    resyncLen = 6'h07;
			3'h1:    resyncLen = 6'h09;
			3'h2:    resyncLen = 6'h0D;
			3'h3:    resyncLen = 6'h11;
			3'h4:    resyncLen = 6'h19;
			default: resyncLen = 6'h21;
		endcase
	endfunction

	always_comb begin
		next_pwr       = pwr;
		next_timer     = timer;
		next_resyncIdx = resyncIdx;
		next_fitted    = fitted;
		next_xip       = xipActive;
		next_vcfg      = vcfgXipBit;
		next_wel       = welBit;
		next_lock      = lockBits;
		bootXip        = bootConfig[BOOT_XIP_HI:BOOT_XIP_LO] != BOOT_XIP_OFF;
		// quad protocol resets only when deselected
		pinReset       = fitted && !rpSync && (protocolLines != LINES_QUAD || csSync);
		// resync frames must carry io0 and io3 high
		resyncHit      = frameEnd && frame.allOnes && frame.clocks == resyncLen(resyncIdx);
		if (frameEnd)
			next_resyncIdx = resyncHit ? resyncIdx + 3'h1 :
				(frame.allOnes && frame.clocks == resyncLen(3'h0)) ? 3'h1 : 3'h0;
		unique case (pwr)
			PWR_OFF: begin
				next_pwr   = PWR_RAMP;
				// stretched ready time after erase loss
				if (eraseInterrupted == ERASE_INT_32K)
					next_timer = TIMER_W'(READY_32K_CYC);
				else if (eraseInterrupted == ERASE_INT_4K)
					next_timer = TIMER_W'(READY_4K_CYC);
				else
					next_timer = TIMER_W'(READY_CYC);
			end
			PWR_RAMP: begin
				next_fitted = resetPinFitted;
				if (timer <= {{(TIMER_W-1){1'b0}}, 1'b1}) begin
					next_pwr  = PWR_READY;
					// come up in XIP from boot config
					next_xip  = bootXip;
				end else
					next_timer = timer - {{(TIMER_W-1){1'b0}}, 1'b1};
			end
			PWR_READY: begin
				// host write first so a hardware set in the same cycle wins
				if (vcfgWrite)
					next_vcfg = vcfgXipDisable;
				if (frameEnd && frame.sawConfirm) begin
					if (!frame.confirm && (xipActive || !vcfgXipBit))
						next_xip = 1'b1;
					else if (frame.confirm && xipActive) begin
						next_xip  = 1'b0;
						next_vcfg = 1'b1;
					end
				end
				// resync ends XIP and sets the disable bit only if XIP was active, nothing else
				if (resyncHit && resyncIdx == RESYNC_LAST) begin
					next_resyncIdx = 3'h0;
					if (xipActive)
						next_vcfg = 1'b1;
					next_xip = 1'b0;
				end
				if (lockLoad)
					next_lock = lockValue;
				if (welClear)
					next_wel = 1'b0;
				if (welSet)
					next_wel = 1'b1;
				if (pinReset) begin
					next_xip       = bootXip;
					next_vcfg      = VCFG_XIP_RESET;
					next_wel       = 1'b0;
					next_resyncIdx = 3'h0;
				end
			end
			default: next_pwr = PWR_OFF;
		endcase
		// busy and ready bits for polling
		next_busy = next_pwr != PWR_READY || opRunning;
		next_flag = next_pwr == PWR_READY && !opRunning;
		// supply below threshold: held in power-off reset, write latch and lock bits cleared
		if (!supSync) begin
			next_pwr       = PWR_OFF;
			next_timer     = '0;
			next_resyncIdx = 3'h0;
			next_xip       = 1'b0;
			next_vcfg      = VCFG_XIP_RESET;
			next_wel       = 1'b0;
			next_lock      = LOCK_RESET;
			next_fitted    = 1'b0;
			next_busy      = 1'b1;
			next_flag      = 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pwr           <= PWR_OFF;
			timer         <= '0;
			resyncIdx     <= 3'h0;
			fitted        <= 1'b0;
			xipActive     <= 1'b0;
			vcfgXipBit    <= VCFG_XIP_RESET;
			welBit        <= 1'b0;
			lockBits      <= LOCK_RESET;
			statusBusyBit <= 1'b1;
			flagReadyBit  <= 1'b0;
			wipBit        <= 1'b1;
		end else begin
			pwr           <= next_pwr;
			timer         <= next_timer;
			resyncIdx     <= next_resyncIdx;
			fitted        <= next_fitted;
			xipActive     <= next_xip;
			vcfgXipBit    <= next_vcfg;
			welBit        <= next_wel;
			lockBits      <= next_lock;
			statusBusyBit <= next_busy;
			flagReadyBit  <= next_flag;
			wipBit        <= next_busy;
		end
	end

	assign powerReady     = pwr == PWR_READY;
	assign pauseEnable    = 1'b1;
	assign resetPinEnable = powerReady & fitted;
	assign driveDefault   = ~powerReady;

endmodule

// *** testbench/xpc_xip_powerup_control_checker.sv ***
`timescale 1ns/10ps
module xpc_xip_powerup_control_checker
	import xpc_pkg::*;
(
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        csN,
	input wire logic        supplyOk,
	input wire logic        resetPinN,
	input wire logic        resetPinFitted,
	input wire logic [15:0] bootConfig,
	input wire logic        opRunning,
	input wire logic        xipActive,
	input wire logic        vcfgXipBit,
	input wire logic        powerReady,
	input wire logic        statusBusyBit,
	input wire logic        flagReadyBit,
	input wire logic        welBit,
	input wire logic        wipBit,
	input wire logic [1:0]  lockBits,
	input wire logic        resetPinEnable,
	input wire logic        driveDefault,
	input wire logic        cmdAllowed,
	input wire logic        addrOnlyFrame
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// ========================================
	// sequences
	sequence supplyLost;
		!supplyOk [*6];
	endsequence
	sequence pinHeld;
		(!resetPinN && csN && resetPinEnable) [*5];
	endsequence
	// ========================================
	// assertions
	supply_lost_a: assert property (supplyLost |-> !powerReady && !xipActive && statusBusyBit)
		else $error("logic not held off after supply loss");
	pin_held_a: assert property (pinHeld |-> xipActive == (bootConfig[11:9] != BOOT_XIP_OFF)
		&& vcfgXipBit && !welBit)
		else $error("reset pin did not restore boot state");
	reset_gate_a: assert property (resetPinEnable |-> powerReady && resetPinFitted)
		else $error("reset pin enabled during power-up");
	drive_default_a: assert property (driveDefault == !powerReady)
		else $error("drive strength not default while ramping");
	ready_clean_a: assert property ($rose(powerReady) |-> lockBits == LOCK_RESET && !welBit)
		else $error("lock or write latch set at ready");
	ready_flags_a: assert property ($rose(powerReady) && !opRunning |-> ##2 !statusBusyBit
		&& flagReadyBit)
		else $error("ready flags not raised after power-up");
	flag_busy_a: assert property (opRunning [*3] |-> !flagReadyBit && wipBit)
		else $error("flag shows ready while operation runs");
	cmd_frame_a: assert property (cmdAllowed |-> !csN)
		else $error("command accepted while deselected");
	addr_frame_a: assert property (addrOnlyFrame |-> !csN && xipActive)
		else $error("address-only frame outside XIP");
	vcfg_exit_a: assert property ($fell(xipActive) |-> vcfgXipBit)
		else $error("XIP left without disable bit set");
endmodule

bind xpc_xip_powerup_control xpc_xip_powerup_control_checker xpc_xip_powerup_control_checker_inst (
	.clock, .rst, .csN, .supplyOk, .resetPinN, .resetPinFitted, .bootConfig, .opRunning,
	.xipActive, .vcfgXipBit, .powerReady, .statusBusyBit, .flagReadyBit, .welBit, .wipBit,
	.lockBits, .resetPinEnable, .driveDefault, .cmdAllowed, .addrOnlyFrame);

// *** testbench/xpc_host_model.sv ***
`timescale 1ns/10ps
module xpc_host_model (
	output logic spiClk,
	output logic csN,
	output logic io0,
	output logic io3
);
	// ========================================
	// idle: deselected, clock parked
	// deselected at power-up
	initial begin
		spiClk = 1'b0;
		csN = 1'b1;
		io0 = 1'b0;
		io3 = 1'b0;
	end
	// one frame, io0 per edge from d[0] up, released lines inverted
	task automatic frame(input int n, input logic [63:0] d, input logic hi3);
		csN = 1'b0;
		for (int k = 0; k < n; k++) begin
			io0 = d[k];
			io3 = hi3;
			#15 spiClk = 1'b1;
			#15 spiClk = 1'b0;
		end
		#15 csN = 1'b1;
		io0 = ~io0;
		io3 = ~io3;
		#200;
	endtask
	task automatic softReset(input logic [7:0] opEn, input logic [7:0] opMem);
		logic [63:0] a, b;
		a = '0;
		b = '0;
		for (int i = 0; i < 8; i++) begin
			a[i] = opEn[7 - i];
			b[i] = opMem[7 - i];
		end
		frame(8, a, 1'b0);
		frame(8, b, 1'b0);
	endtask
	task automatic resync();
		int lens[6] = '{7, 9, 13, 17, 25, 33};
		foreach (lens[i]) frame(lens[i], {64{1'b1}}, 1'b1);
	endtask
endmodule

// *** testbench/test_xpc_xip_powerup_control.sv ***
`timescale 1ns/10ps
module test_xpc_xip_powerup_control
	import xpc_pkg::*;
;
	localparam logic [7:0]  OP_QR = 8'h03;
	localparam logic [15:0] BOOT  = 16'hF1FF;
	logic       clock, rst, supplyOk, resetPinN, opRunning, welSet, lockLoad;
	logic       vcfgWrite, vcfgXipDisable, spiClk, csN, io0, io3;
	logic [1:0] eraseInterrupted, lockValue, lockBits;
	logic       xipActive, vcfgXipBit, powerReady, statusBusyBit, flagReadyBit, welBit;
	logic       wipBit, pauseEnable, resetPinEnable, driveDefault, cmdAllowed, addrOnlyFrame;
	int         bad_count = 0;
	int         checks = 0;
	int         n;
	// ========================================
	// instances
	xpc_xip_powerup_control #(.READY_CYC(20), .READY_4K_CYC(40), .READY_32K_CYC(60),
		.OP_QUAD_READ(OP_QR)) xpc_xip_powerup_control_inst (
		.clock, .rst, .spiClk, .csN, .io0In(io0), .io3In(io3), .supplyOk, .resetPinN,
		.resetPinFitted(1'b1), .bootConfig(BOOT), .protocolLines(LINES_QUAD), .eraseInterrupted,
		.opRunning, .welSet, .welClear(1'b0), .lockLoad, .lockValue, .vcfgWrite, .vcfgXipDisable,
		.xipActive, .vcfgXipBit, .powerReady, .statusBusyBit, .flagReadyBit, .welBit, .wipBit,
		.lockBits, .pauseEnable, .resetPinEnable, .driveDefault, .cmdAllowed, .addrOnlyFrame);
	xpc_host_model xpc_host_model_inst (.spiClk, .csN, .io0, .io3);
	// ========================================
	// helpers
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic clk(input int k);
		repeat (k) @(negedge clock);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	function automatic logic [63:0] rd(input logic [7:0] op, input int at, input logic c);
		logic [63:0] d;
		d = '0;
		for (int i = 0; i < 8; i++) d[i] = op[7 - i];
		d[at] = c;
		return d;
	endfunction
	task automatic waitReady();
		n = 0;
		while (powerReady !== 1'b1 && n < 300) begin
			clk(1);
			n++;
		end
	endtask
	initial begin
		#200000;
		bad_count++;
		results();
	end
	// ========================================
	// tests
	initial begin
		rst = 1'b1;
		{supplyOk, opRunning, welSet, lockLoad, vcfgWrite} = '0;
		{resetPinN, vcfgXipDisable} = 2'h3;
		eraseInterrupted = 2'h0;
		lockValue = 2'h0;
		clk(2);
		rst = 1'b0;
		supplyOk = 1'b1;
		clk(8);
		check("powerReady", powerReady, 8'h00);
		check("driveDefault", driveDefault, 8'h01);
		check("resetPinEnable", resetPinEnable, 8'h00);
		check("pauseEnable", pauseEnable, 8'h01);
		waitReady();
		check("readyDelay", 8'(n + 8 >= 21 && n + 8 <= 26), 8'h01);
		clk(2);
		check("xipActive", xipActive, 8'h01);
		check("welBit", welBit, 8'h00);
		check("wipBit", wipBit, 8'h00);
		check("lockBits", lockBits, 8'h00);
		check("flagReadyBit", flagReadyBit, 8'h01);
		check("statusBusyBit", statusBusyBit, 8'h00);
		check("resetPinEnable", resetPinEnable, 8'h01);
		$display("test power-up done");
		fork
			xpc_host_model_inst.frame(7, rd(8'h00, 6, 1'b0), 1'b0);
			begin
				#100;
				check("addrOnlyFrame", addrOnlyFrame, 8'h01);
			end
		join
		clk(4);
		check("xipKept", xipActive, 8'h01);
		xpc_host_model_inst.frame(7, rd(8'h00, 6, 1'b1), 1'b1);
		clk(4);
		check("xipExit", xipActive, 8'h00);
		check("vcfgXipBit", vcfgXipBit, 8'h01);
		vcfgXipDisable = 1'b0;
		vcfgWrite = 1'b1;
		clk(1);
		vcfgWrite = 1'b0;
		xpc_host_model_inst.frame(15, rd(OP_QR, 14, 1'b0), 1'b1);
		clk(4);
		check("xipEnter", xipActive, 8'h01);
		$display("test confirm bit done");
		opRunning = 1'b1;
		xpc_host_model_inst.resync();
		clk(4);
		check("xipResync", xipActive, 8'h00);
		check("wipBusy", wipBit, 8'h01);
		check("flagBusy", flagReadyBit, 8'h00);
		xpc_host_model_inst.softReset(8'h06, 8'h07);
		clk(2);
		check("softReset", xipActive, 8'h00);
		opRunning = 1'b0;
		clk(3);
		check("flagDone", flagReadyBit, 8'h01);
		$display("test resync done");
		welSet = 1'b1;
		lockValue = 2'h3;
		lockLoad = 1'b1;
		clk(1);
		{welSet, lockLoad} = 2'h0;
		clk(2);
		check("welSet", welBit, 8'h01);
		check("lockLoad", lockBits, 8'h03);
		fork
			xpc_host_model_inst.frame(33, {64{1'b1}}, 1'b1);
			begin
				#280 resetPinN = 1'b0;
				#400 resetPinN = 1'b1;
			end
		join
		clk(4);
		check("pinSelected", xipActive, 8'h00);
		check("welKept", welBit, 8'h01);
		resetPinN = 1'b0;
		clk(6);
		resetPinN = 1'b1;
		clk(2);
		check("pinXip", xipActive, 8'h01);
		check("pinVcfg", vcfgXipBit, 8'h01);
		check("pinWel", welBit, 8'h00);
		$display("test reset pin done");
		supplyOk = 1'b0;
		clk(6);
		check("offReady", powerReady, 8'h00);
		check("offXip", xipActive, 8'h00);
		check("offBusy", statusBusyBit, 8'h01);
		eraseInterrupted = ERASE_INT_4K;
		supplyOk = 1'b1;
		waitReady();
		check("ready4k", 8'(n >= 40 && n <= 48), 8'h01);
		$display("test power loss done");
		results();
	end
endmodule
